// ### verilog/ccpce_pkg.sv
// constants shared by the compare, special-event and pwm unit slice
// assumes a 32-bit apb slave on pclk and byte-wide unit registers
package ccpce_pkg;

	// ===========================================================
	// register byte addresses
	localparam logic [7:0] ADDR_UNIT_CONTROL = 8'h00;
	localparam logic [7:0] ADDR_MATCH_LOW = 8'h04;
	localparam logic [7:0] ADDR_MATCH_HIGH = 8'h08;
	localparam logic [7:0] ADDR_TIMER_SELECT = 8'h0C;
	localparam logic [7:0] ADDR_STATUS = 8'h10;

	// ===========================================================
	// unit control field layout
	localparam int MODE_LSB = 0;
	localparam int MODE_MSB = 3;
	localparam int DUTY_LSB = 4;
	localparam int DUTY_MSB = 5;
	localparam int STEER_LSB = 6;
	localparam int STEER_MSB = 7;
	localparam logic [7:0] STEER_MASK = 8'hC0;

	// status register bit positions
	localparam int STAT_FLAG_BIT = 0;
	localparam int STAT_PIN_BIT = 1;
	localparam int STAT_PEND_BIT = 2;

	// ===========================================================
	// mode field encodings
	localparam logic [3:0] MODE_OFF = 4'h0;
	localparam logic [3:0] MODE_TOGGLE = 4'h2;
	localparam logic [3:0] MODE_SET = 4'h8;
	localparam logic [3:0] MODE_CLEAR = 4'h9;
	localparam logic [3:0] MODE_SOFT_INT = 4'hA;
	localparam logic [3:0] MODE_SPECIAL = 4'hB;
	localparam logic [1:0] MODE_PWM_TOP = 2'h3;

	// ===========================================================
	// widths and reset values
	localparam int NUM_PERIOD_TIMERS = 3;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [9:0] DUTY_ZERO = 10'h000;
	localparam logic [31:0] WORD_ZERO = 32'h00000000;
	localparam logic [1:0] TSEL_RESET = 2'h0;

endpackage : ccpce_pkg

// ### verilog/ccpce_pwm.sv
// standard pwm generator: 10-bit time base against a double-buffered duty
// assumes the period timers live outside and report count and increments
`timescale 1ns/1ps

module ccpce_pwm (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pwm_enable,
	input wire logic [1:0] period_timer_select,
	input wire logic [9:0] duty_value,
	input wire logic [ccpce_pkg::NUM_PERIOD_TIMERS-1:0][7:0] period_timer_count,
	input wire logic [ccpce_pkg::NUM_PERIOD_TIMERS-1:0][7:0] period_register,
	input wire logic [ccpce_pkg::NUM_PERIOD_TIMERS-1:0][1:0] period_timer_low2,
	input wire logic [ccpce_pkg::NUM_PERIOD_TIMERS-1:0] period_timer_inc,
	output logic pwm_level,
	output logic [9:0] duty_latched
);
	import ccpce_pkg::*;

	// ===========================================================
	// timer selection
	// maps the 2-bit select onto a timer index, spare code picks timer 0
	function automatic int unsigned timer_index(input logic [1:0] sel);
		timer_index = (sel == 2'h1) ? 1 : (sel == 2'h2) ? 2 : 0;
	endfunction : timer_index

	logic [7:0] sel_count;
	logic [7:0] sel_period;
	logic [1:0] sel_low2;
	logic sel_inc;
	logic [9:0] time_base;
	logic rollover;

	always_comb begin
		sel_count = period_timer_count[timer_index(period_timer_select)];
		sel_period = period_register[timer_index(period_timer_select)];
		sel_low2 = period_timer_low2[timer_index(period_timer_select)];
		sel_inc = period_timer_inc[timer_index(period_timer_select)];
		time_base = {sel_count, sel_low2};
		rollover = sel_inc && (sel_count == sel_period);
	end

	// ===========================================================
	// waveform state
	logic level_reg;
	logic level_next;
	logic [9:0] buffer_reg;
	logic [9:0] buffer_next;

	// one time-base step; the pin is registered, so the fall is decided
	// a step early and lands on the edge where the time base hits duty
	localparam logic [9:0] TB_STEP = 10'h001;

	always_comb begin
		level_next = level_reg;
		buffer_next = buffer_reg;
		if (!pwm_enable) begin
			level_next = 1'b0;
		end else if (rollover) begin
			level_next = (duty_value != DUTY_ZERO);
			buffer_next = duty_value;
		end else if ((time_base + TB_STEP) == buffer_reg) begin
			level_next = 1'b0;
		end
	end

	// registers the waveform state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			level_reg <= 1'b0;
			buffer_reg <= DUTY_ZERO;
		end else begin
			level_reg <= level_next;
			buffer_reg <= buffer_next;
		end
	end

	assign pwm_level = level_reg;
	assign duty_latched = buffer_reg;

endmodule : ccpce_pwm

// ### verilog/ccpce_unit.sv
// one compare / special-event / standard pwm unit with an apb register file
// assumes timer a, the period timers and the converter sit on pclk
//
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps

// Contract
// - mode 1010 only sets the match flag; pin is not driven.
// - mode 1011 match clears timer a and starts conversion if enabled.
// - special event output rises in the same cycle as the match.
// - timer a clears only on its next count clock edge after match.
// - match registers thus act as a 16-bit period for timer a.
// - special event timer clear never sets timer a overflow flag.
// - rewriting match registers before that edge cancels the pending clear.
// - compare works only while the system clock runs.
// - pwm mode drives the pin with up to 10-bit duty resolution.
// - period timer, its control, duty bits and control set the waveform.
// - writing zero to unit control releases the pin.
// - a 2-bit select picks one of three 8-bit period timers.
// - compare and pwm behaviour is identical in every unit instance.
// - steering bits exist only on enhanced units; duty and mode common.
// - unimplemented register bits read as zero.
// - match flag sets together with the selected pin action.
// - after period match, timer clears, pin rises unless zero, duty latches.
// - pin falls when time base equals the latched 10-bit duty.
module ccpce_unit #(
	parameter bit ENHANCED = 1'b1
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [15:0] timer_a_count,
	input wire logic timer_a_tick,
	input wire logic adc_enabled,
	input wire logic [ccpce_pkg::NUM_PERIOD_TIMERS-1:0][7:0] period_timer_count,
	input wire logic [ccpce_pkg::NUM_PERIOD_TIMERS-1:0][7:0] period_register,
	input wire logic [ccpce_pkg::NUM_PERIOD_TIMERS-1:0][1:0] period_timer_low2,
	input wire logic [ccpce_pkg::NUM_PERIOD_TIMERS-1:0] period_timer_inc,
	output logic unit_output_pin,
	output logic unit_output_pin_oe,
	output logic unit_match_flag,
	output logic special_event,
	output logic adc_start,
	output logic timer_a_clear
);
	import ccpce_pkg::*;

	// ===========================================================
	// bus decode
	// true when the address hits a mapped register
	function automatic logic addr_mapped(input logic [7:0] a);
		addr_mapped = (a == ADDR_UNIT_CONTROL) || (a == ADDR_MATCH_LOW) ||
			(a == ADDR_MATCH_HIGH) || (a == ADDR_TIMER_SELECT) ||
			(a == ADDR_STATUS);
	endfunction : addr_mapped

	logic wr_access;
	logic rd_setup;

	// zero-wait slave; error on unmapped addresses
	always_comb begin
		pready = 1'b1;
		pslverr = psel && penable && !addr_mapped(paddr);
		wr_access = psel && penable && pwrite && addr_mapped(paddr);
		rd_setup = psel && !penable && !pwrite;
	end

	// ===========================================================
	// register state
	logic [7:0] control_reg;
	logic [7:0] control_next;
	logic [7:0] match_low_reg;
	logic [7:0] match_low_next;
	logic [7:0] match_high_reg;
	logic [7:0] match_high_next;
	logic [1:0] tsel_reg;
	logic [1:0] tsel_next;
	logic flag_reg;
	logic flag_next;
	logic pin_latch_reg;
	logic pin_latch_next;
	logic match_prev_reg;
	logic match_prev_next;
	logic pending_reg;
	logic pending_next;
	logic adc_pulse_reg;
	logic adc_pulse_next;
	logic [31:0] prdata_reg;
	logic [31:0] prdata_next;

	logic [3:0] mode;
	logic pwm_mode;
	logic compare_mode;
	logic match;
	logic match_rise;
	logic pwm_level;
	logic [9:0] duty_latched;
	logic [7:0] steer_keep;

	// ===========================================================
	// mode decode and match detection
	always_comb begin
		mode = control_reg[MODE_MSB:MODE_LSB];
		pwm_mode = (mode[3:2] == MODE_PWM_TOP);
		compare_mode = (mode == MODE_TOGGLE) || (mode == MODE_SET) ||
			(mode == MODE_CLEAR) || (mode == MODE_SOFT_INT) ||
			(mode == MODE_SPECIAL);
		match = ({match_high_reg, match_low_reg} == timer_a_count);
		match_rise = compare_mode && match && !match_prev_reg;
		steer_keep = ENHANCED ? STEER_MASK : BYTE_ZERO;
	end

	assign special_event = (mode == MODE_SPECIAL) && match;

	// ===========================================================
	// register writes
	always_comb begin
		control_next = control_reg;
		match_low_next = match_low_reg;
		match_high_next = match_high_reg;
		tsel_next = tsel_reg;
		if (wr_access) begin
			case (paddr)
				ADDR_UNIT_CONTROL: begin
					control_next = pwdata[7:0] & (steer_keep | ~STEER_MASK);
				end
				ADDR_MATCH_LOW: begin
					match_low_next = pwdata[7:0];
				end
				ADDR_MATCH_HIGH: begin
					// high byte is read-only while pwm runs
					if (!pwm_mode) begin
						match_high_next = pwdata[7:0];
					end
				end
				ADDR_TIMER_SELECT: begin
					tsel_next = pwdata[1:0];
				end
				default: begin
				end
			endcase
		end
	end

	// ===========================================================
	// compare actions, flag and special event
	always_comb begin
		pin_latch_next = pin_latch_reg;
		flag_next = flag_reg;
		pending_next = pending_reg;
		adc_pulse_next = 1'b0;
		match_prev_next = match;
		if (match_rise) begin
			case (mode)
				MODE_TOGGLE: begin
					pin_latch_next = !pin_latch_reg;
				end
				MODE_SET: begin
					pin_latch_next = 1'b1;
				end
				MODE_CLEAR: begin
					pin_latch_next = 1'b0;
				end
				default: begin
					pin_latch_next = pin_latch_reg;
				end
			endcase
		end
		if (mode == MODE_OFF) begin
			pin_latch_next = 1'b0;
		end
		// write one clears; a new match wins
		if (wr_access && (paddr == ADDR_STATUS) && pwdata[STAT_FLAG_BIT]) begin
			flag_next = 1'b0;
		end
		if (match_rise) begin
			flag_next = 1'b1;
		end
		if (special_event && !pending_reg) begin
			pending_next = 1'b1;
			adc_pulse_next = adc_enabled;
		end
		if (!special_event || timer_a_tick) begin
			pending_next = special_event && !timer_a_tick;
		end
	end

	assign timer_a_clear = pending_reg && special_event && timer_a_tick;
	assign adc_start = adc_pulse_reg;
	assign unit_match_flag = flag_reg;

	// ===========================================================
	// pin steering
	// zero control releases pin
	always_comb begin
		unit_output_pin = 1'b0;
		unit_output_pin_oe = 1'b0;
		case (mode)
			MODE_TOGGLE, MODE_SET, MODE_CLEAR: begin
				unit_output_pin = pin_latch_reg;
				unit_output_pin_oe = 1'b1;
			end
			MODE_SOFT_INT, MODE_SPECIAL: begin
				unit_output_pin_oe = 1'b0;
			end
			default: begin
				if (pwm_mode) begin
					unit_output_pin = pwm_level;
					unit_output_pin_oe = 1'b1;
				end
			end
		endcase
	end

	// ===========================================================
	// read data, captured in the setup phase
	// unused bits read zero
	always_comb begin
		prdata_next = prdata_reg;
		if (rd_setup) begin
			prdata_next = WORD_ZERO;
			case (paddr)
				ADDR_UNIT_CONTROL: begin
					prdata_next[7:0] = control_reg;
				end
				ADDR_MATCH_LOW: begin
					prdata_next[7:0] = match_low_reg;
				end
				ADDR_MATCH_HIGH: begin
					prdata_next[7:0] = pwm_mode ? duty_latched[9:2] :
						match_high_reg;
				end
				ADDR_TIMER_SELECT: begin
					prdata_next[1:0] = tsel_reg;
				end
				ADDR_STATUS: begin
					prdata_next[STAT_FLAG_BIT] = flag_reg;
					prdata_next[STAT_PIN_BIT] = unit_output_pin;
					prdata_next[STAT_PEND_BIT] = pending_reg;
				end
				default: begin
					prdata_next = WORD_ZERO;
				end
			endcase
		end
	end

	assign prdata = prdata_reg;

	// ===========================================================
	// state registers
	// all state runs on pclk
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			control_reg <= BYTE_ZERO;
			match_low_reg <= BYTE_ZERO;
			match_high_reg <= BYTE_ZERO;
			tsel_reg <= TSEL_RESET;
			flag_reg <= 1'b0;
			pin_latch_reg <= 1'b0;
			match_prev_reg <= 1'b0;
			pending_reg <= 1'b0;
			adc_pulse_reg <= 1'b0;
			prdata_reg <= WORD_ZERO;
		end else begin
			control_reg <= control_next;
			match_low_reg <= match_low_next;
			match_high_reg <= match_high_next;
			tsel_reg <= tsel_next;
			flag_reg <= flag_next;
			pin_latch_reg <= pin_latch_next;
			match_prev_reg <= match_prev_next;
			pending_reg <= pending_next;
			adc_pulse_reg <= adc_pulse_next;
			prdata_reg <= prdata_next;
		end
	end

	// ===========================================================
	// standard pwm engine
	// same engine in every instance
	ccpce_pwm u_pwm (
		.pclk(pclk),
		.presetn(presetn),
		.pwm_enable(pwm_mode),
		.period_timer_select(tsel_reg),
		.duty_value({match_low_reg, control_reg[DUTY_MSB:DUTY_LSB]}),
		.period_timer_count(period_timer_count),
		.period_register(period_register),
		.period_timer_low2(period_timer_low2),
		.period_timer_inc(period_timer_inc),
		.pwm_level(pwm_level),
		.duty_latched(duty_latched)
	);

endmodule : ccpce_unit

// ### sim/ccpce_unit_assertions.sv
// port checker for the compare and pwm unit slice
// assumes it is bound onto ccpce_unit
`timescale 1ns/1ps
module ccpce_unit_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic unit_output_pin_oe,
	input wire logic unit_match_flag,
	input wire logic special_event,
	input wire logic adc_enabled,
	input wire logic adc_start,
	input wire logic timer_a_tick,
	input wire logic timer_a_clear
);
	import ccpce_pkg::*;
	// =======
	// completed write of zero to unit control
	wire logic wr_off = psel && penable && pwrite &&
		paddr == ADDR_UNIT_CONTROL && pwdata[7:0] == 8'h00;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_adc_follow: assert property (
		$rose(special_event) && adc_enabled |=> adc_start)
		else $error("conversion start missing");
	a_adc_single: assert property (
		adc_start |=> !adc_start) else $error("conversion start too long");
	a_adc_cause: assert property (
		adc_start |-> $past(special_event)) else $error("stray conversion");
	a_clear_tick: assert property (
		timer_a_clear |-> timer_a_tick && special_event)
		else $error("restart off the count clock");
	a_clear_late: assert property (
		$rose(special_event) |-> !timer_a_clear)
		else $error("restart at match instant");
	a_event_nodrive: assert property (
		special_event |-> !unit_output_pin_oe) else $error("pin driven");
	a_flag_event: assert property (
		$rose(special_event) |=> unit_match_flag) else $error("flag not set");
	a_zero_release: assert property (
		wr_off |=> !unit_output_pin_oe) else $error("pin kept");
endmodule : ccpce_unit_chk

bind ccpce_unit ccpce_unit_chk u_ccpce_unit_chk (.pclk, .presetn, .psel,
	.penable, .pwrite, .paddr, .pwdata, .unit_output_pin_oe,
	.unit_match_flag, .special_event, .adc_enabled, .adc_start,
	.timer_a_tick, .timer_a_clear);

// ### sim/ccpce_far_end.sv
// far side model: timer a with its count clock, three period timers
// assumes the unit asks for the restart inside a tick cycle
`timescale 1ns/1ps
module ccpce_far_end (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic timer_a_clear,
	output logic [15:0] timer_a_count,
	output logic timer_a_tick,
	output logic timer_a_overflow_flag,
	output logic [2:0][7:0] period_timer_count,
	output logic [2:0][7:0] period_register,
	output logic [2:0][1:0] period_timer_low2,
	output logic [2:0] period_timer_inc
);
	import ccpce_pkg::*;
	logic [2:0] div_reg;
	logic [1:0] low_reg;
	// count clock every eighth cycle, periods 3, 5 and 7
	assign timer_a_tick = (div_reg == 3'h7);
	assign period_register = {8'h07, 8'h05, 8'h03};
	assign period_timer_low2 = {3{low_reg}};
	assign period_timer_inc = {3{low_reg == 2'h3}};
	// =======
	// timers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_reg <= 3'h0;
			low_reg <= 2'h0;
			timer_a_count <= 16'h0000;
			timer_a_overflow_flag <= 1'h0;
			period_timer_count <= 24'h000000;
		end else begin
			div_reg <= div_reg + 3'h1;
			low_reg <= low_reg + 2'h1;
			if (timer_a_tick && timer_a_clear) begin
				timer_a_count <= 16'h0000;
			end else if (timer_a_tick) begin
				timer_a_count <= timer_a_count + 16'h0001;
				if (timer_a_count == 16'hFFFF) timer_a_overflow_flag <= 1'h1;
			end
			for (int i = 0; i < 3; i++) begin
				if (low_reg == 2'h3) begin
					period_timer_count[i] <= period_timer_count[i] + 8'h01;
					if (period_timer_count[i] == period_register[i])
						period_timer_count[i] <= 8'h00;
				end
			end
		end
	end
endmodule : ccpce_far_end

// ### sim/tb_ccpce_unit.sv
// self-checking bench for the unit slice over apb
// assumes the far side model and the bound checker
`timescale 1ns/1ps
module tb_ccpce_unit;
	import ccpce_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, adc_enabled;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic pready, pslverr, err, pin, oe, flag, sev, ast, tclr, tick, ovf;
	logic [15:0] tcnt, mv;
	logic [2:0][7:0] ptc, preg;
	logic [2:0][1:0] pl2;
	logic [2:0] pinc;
	int n_fail, total_checks, cyc, clr_cnt, n, t0, hi, per, hi1;
	int adc_cnt;
	bit spec_on;
	logic [7:0] adr [5] = '{ADDR_UNIT_CONTROL, ADDR_MATCH_LOW,
		ADDR_MATCH_HIGH, ADDR_TIMER_SELECT, ADDR_STATUS};
	logic [3:0] md [6] = '{MODE_SET, MODE_TOGGLE, MODE_TOGGLE, MODE_CLEAR,
		MODE_SET, MODE_SOFT_INT};
	logic [5:0] ep = 6'h15;
	logic [1:0] dl [2] = '{2'h2, 2'h1};
	logic [7:0] dh [2] = '{8'h01, 8'h03};
	ccpce_unit u_ccpce_unit (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .timer_a_count(tcnt),
		.timer_a_tick(tick), .adc_enabled, .period_timer_count(ptc),
		.period_register(preg), .period_timer_low2(pl2),
		.period_timer_inc(pinc), .unit_output_pin(pin),
		.unit_output_pin_oe(oe), .unit_match_flag(flag),
		.special_event(sev), .adc_start(ast), .timer_a_clear(tclr));
	ccpce_far_end u_ccpce_far_end (.pclk, .presetn, .timer_a_clear(tclr),
		.timer_a_count(tcnt), .timer_a_tick(tick),
		.timer_a_overflow_flag(ovf), .period_timer_count(ptc),
		.period_register(preg), .period_timer_low2(pl2),
		.period_timer_inc(pinc));
	initial begin
		pclk = 1'h0;
		forever #10 pclk = ~pclk;
	end
	// cycle count and restarts seen
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (tclr === 1'h1) clr_cnt <= clr_cnt + 1;
		if (ast === 1'h1) adc_cnt <= adc_cnt + 1;
	end
	// event output follows the live match
	always @(negedge pclk) begin
		if (spec_on) chk(sev, 32'(tcnt == mv));
	end
	// =======
	// tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %0h want %0h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		// waits until pready is high; the watchdog ends a stuck wait
		do begin
			@(posedge pclk);
		end while (pready !== 1'h1);
		q = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		apb(1'h0, a, 32'h0);
		chk(q, e);
	endtask : rdc
	task automatic set_m(input logic [15:0] v);
		mv = v;
		apb(1'h1, ADDR_MATCH_LOW, {24'h0, v[7:0]});
		apb(1'h1, ADDR_MATCH_HIGH, {24'h0, v[15:8]});
	endtask : set_m
	function automatic logic sig(input int k);
		case (k)
			0: return flag;
			1: return sev;
			2: return tclr;
			default: return pin;
		endcase
	endfunction : sig
	task automatic wait_ev(input int k);
		int w;
		w = 0;
		while (sig(k) !== 1'h1 && w < 3000) begin
			@(negedge pclk);
			w++;
		end
		if (w == 3000) chk(0, 1);
	endtask : wait_ev
	// one whole period, rise to rise
	task automatic meas(output int h, output int p);
		logic pv;
		p = 0;
		while (pin !== 1'h0 && p < 300) begin
			@(negedge pclk);
			p++;
		end
		wait_ev(3);
		h = 0;
		p = 0;
		do begin
			h += (pin === 1'h1);
			p++;
			pv = pin;
			@(negedge pclk);
		end while (!(pin === 1'h1 && pv === 1'h0) && p < 300);
	endtask : meas
	task automatic wrap_up;
		if (n_fail == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : wrap_up
	initial begin
		repeat (30000) @(posedge pclk);
		n_fail++;
		wrap_up;
	end
	// =======
	// scenarios
	initial begin
		presetn = 1'h0;
		{psel, penable, pwrite, paddr, pwdata, adc_enabled} = 44'h0;
		repeat (20) @(posedge pclk);
		presetn <= 1'h1;
		foreach (adr[i]) rdc(adr[i], 32'h0);
		apb(1'h0, 8'h14, 32'h0);
		chk({q[31:1], err}, 32'h1);
		apb(1'h1, ADDR_UNIT_CONTROL, 32'hFF);
		rdc(ADDR_UNIT_CONTROL, 32'hFF);
		apb(1'h1, ADDR_TIMER_SELECT, 32'hFFFFFFFF);
		rdc(ADDR_TIMER_SELECT, 32'h3);
		for (int i = 0; i < 6; i++) begin
			apb(1'h1, ADDR_UNIT_CONTROL, {28'h0, md[i]});
			set_m(tcnt + 16'h0006);
			wait_ev(0);
			chk(oe, 32'(md[i] != MODE_SOFT_INT));
			if (oe === 1'h1) chk(pin, ep[i]);
			apb(1'h1, ADDR_STATUS, 32'h1);
			@(negedge pclk);
			chk(flag, 32'h0);
		end
		apb(1'h1, ADDR_UNIT_CONTROL, 32'h0);
		@(negedge pclk);
		chk(oe, 32'h0);
		rdc(ADDR_STATUS, 32'h0);
		adc_enabled <= 1'h1;
		apb(1'h1, ADDR_UNIT_CONTROL, {28'h0, MODE_SPECIAL});
		set_m(tcnt + 16'h0004);
		spec_on = 1'h1;
		wait_ev(2);
		t0 = cyc;
		@(negedge pclk);
		chk(tcnt, 32'h0);
		wait_ev(2);
		chk(cyc - t0, (mv + 1) * 8);
		chk(ovf, 32'h0);
		spec_on = 1'h0;
		@(negedge pclk);
		wait_ev(1);
		n = clr_cnt;
		apb(1'h1, ADDR_MATCH_HIGH, {24'h0, mv[15:8] + 8'h01});
		repeat (12) @(negedge pclk);
		chk(clr_cnt, n);
		rdc(ADDR_STATUS, 32'h1);
		chk(adc_cnt, 32'h3);
		for (int s = 0; s < 3; s++) begin
			// driver off, mode with duty, then timer pick
			apb(1'h1, ADDR_UNIT_CONTROL, 32'h0);
			for (int d = 0; d < 2; d++) begin
				apb(1'h1, ADDR_UNIT_CONTROL, {26'h0, dl[d], 4'hC});
				apb(1'h1, ADDR_MATCH_LOW, {24'h0, dh[d]});
				apb(1'h1, ADDR_TIMER_SELECT, s);
				meas(hi, per);
				meas(hi, per);
				if (d == 0) hi1 = hi;
			end
			chk(per, (s * 2 + 4) * 4);
			chk(hi - hi1, 32'h7);
			chk(hi1, 32'h6);
			chk(oe, 32'h1);
		end
		rdc(ADDR_MATCH_HIGH, 32'h3);
		apb(1'h1, ADDR_MATCH_LOW, 32'h0);
		apb(1'h1, ADDR_UNIT_CONTROL, 32'hC);
		repeat (80) @(negedge pclk);
		hi = 0;
		repeat (64) begin
			@(negedge pclk);
			hi += (pin !== 1'h0);
		end
		chk(hi, 32'h0);
		wrap_up;
	end
endmodule : tb_ccpce_unit
